// File: hdl/watchdog_timer.sv
// watchdog timer with secure clear, apb register slave
`timescale 1ns/1ps
module watchdog_timer (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        tick_pll_32k,
  input  wire logic        tick_osc_32k,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             timer_irq,
  output logic             wdt_reset_req,
  output logic             watchdog_active
);

  // ---------------------------------------------------------------
  // state and decode
  // ---------------------------------------------------------------
  wdt_pkg::wdt_state_type s_reg;
  wdt_pkg::wdt_state_type s_next;

  logic        sel_load;
  logic        sel_value;
  logic        sel_ctrl;
  logic        sel_clear;
  logic        mapped;
  logic        wr_acc;
  logic        wd_mode;
  logic        secure_on;
  logic        count_up;
  logic        periodic;
  logic        run;
  logic        tick;
  logic [7:0]  presc_term;
  logic        step;
  logic        clear_write;
  logic        secure_ok;
  logic        service_ok;
  logic        secure_fail;
  logic        wd_expire;
  logic [15:0] norm_count;
  logic        norm_event;
  logic [31:0] rd_word;

  // address decode of the four word registers
  assign sel_load  = (paddr == wdt_pkg::LOAD_OFFSET);
  assign sel_value = (paddr == wdt_pkg::VALUE_OFFSET);
  assign sel_ctrl  = (paddr == wdt_pkg::CONTROL_OFFSET);
  assign sel_clear = (paddr == wdt_pkg::CLEAR_OFFSET);
  assign mapped    = sel_load | sel_value | sel_ctrl | sel_clear;

  // reads wait one cycle for the registered read word
  assign pready  = clk_en & (pwrite | s_reg.rd_ready);
  assign pslverr = psel & penable & ~mapped;
  assign wr_acc  = psel & penable & pwrite & pready & mapped;

  // control fields
  assign wd_mode   = s_reg.ctrl[wdt_pkg::CTRL_WATCHDOG_BIT];
  assign secure_on = s_reg.ctrl[wdt_pkg::CTRL_SECURE_BIT];
  assign count_up  = s_reg.ctrl[wdt_pkg::CTRL_COUNT_UP_BIT] & ~wd_mode;
  assign periodic  = s_reg.ctrl[wdt_pkg::CTRL_PERIODIC_BIT];

  // ---------------------------------------------------------------
  // tick source and prescaler
  // ---------------------------------------------------------------
  // watchdog runs on the oscillator tick, normal mode on the pll tick
  assign tick = wd_mode ? tick_osc_32k : tick_pll_32k;
  assign run  = wd_mode | s_reg.ctrl[wdt_pkg::CTRL_ENABLE_BIT];
  assign presc_term = wdt_pkg::presc_terminal(wdt_pkg::presc_sel_type'(
    s_reg.ctrl[wdt_pkg::CTRL_PRESC_HI_BIT:wdt_pkg::CTRL_PRESC_LO_BIT]));
  assign step = run & tick & (s_reg.presc == presc_term);

  // ---------------------------------------------------------------
  // service and secure compare
  // ---------------------------------------------------------------
  assign clear_write = wr_acc & sel_clear;
  // a zero state never matches, so a zero seed always trips
  assign secure_ok   = (pwdata[7:0] == s_reg.lfsr) & (s_reg.lfsr != wdt_pkg::LFSR_ZERO);
  assign service_ok  = wd_mode & clear_write & (~secure_on | secure_ok);
  assign secure_fail = wd_mode & clear_write & secure_on & ~secure_ok;
  assign wd_expire   = wd_mode & step & (s_reg.value == wdt_pkg::COUNT_ZERO);

  // normal mode next count, up or down, free-run or periodic
  always_comb begin
    norm_count = s_reg.value;
    if (count_up) begin
      if (s_reg.value == wdt_pkg::COUNT_FULL) begin
        norm_count = periodic ? s_reg.load : wdt_pkg::COUNT_ZERO;
      end else begin
        norm_count = s_reg.value + 16'h0001;
      end
    end else begin
      if (s_reg.value == wdt_pkg::COUNT_ZERO) begin
        norm_count = periodic ? s_reg.load : wdt_pkg::COUNT_FULL;
      end else begin
        norm_count = s_reg.value - 16'h0001;
      end
    end
  end

  // interrupt when the count arrives at its limit
  assign norm_event = ~wd_mode & step &
                      (norm_count == (count_up ? wdt_pkg::COUNT_FULL : wdt_pkg::COUNT_ZERO));

  // read multiplexer; clear register and lfsr read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (sel_load) begin
      rd_word = {16'h0000, s_reg.load};
    end else if (sel_value) begin
      rd_word = {16'h0000, s_reg.value};
    end else if (sel_ctrl) begin
      rd_word = {23'h000000, s_reg.ctrl};
    end else if (sel_clear) begin
      rd_word = 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    // prescaler advances on each tick of the selected source while the timer runs
    if (run & tick) begin
      s_next.presc = (s_reg.presc == presc_term) ? wdt_pkg::PRESC_RESET : s_reg.presc + 8'h01;
    end
    // counter step
    if (step) begin
      if (wd_mode) begin
        if (wd_expire) begin
          s_next.value = s_reg.load;
        end else begin
          s_next.value = s_reg.value - 16'h0001;
        end
      end else begin
        s_next.value = norm_count;
      end
    end
    // register writes; load and control are locked in watchdog mode
    if (wr_acc & sel_load & ~wd_mode) begin
      s_next.load = pwdata[15:0];
    end
    if (wr_acc & sel_ctrl & ~wd_mode) begin
      s_next.ctrl  = pwdata[8:0] & wdt_pkg::CTRL_WRITE_MASK;
      s_next.value = s_reg.load;
      s_next.presc = wdt_pkg::PRESC_RESET;
    end
    // clear register: seed before watchdog, service during it
    if (clear_write & ~wd_mode) begin
      s_next.lfsr = pwdata[7:0];
    end
    if (service_ok) begin
      s_next.value = s_reg.load;
      s_next.presc = wdt_pkg::PRESC_RESET;
      if (secure_on) begin
        s_next.lfsr = wdt_pkg::lfsr_next(s_reg.lfsr);
      end
    end
    // interrupt flag: clear first so a same-cycle event wins
    if (clear_write) begin
      s_next.irq = 1'b0;
    end
    if (norm_event | (wd_expire & s_reg.ctrl[wdt_pkg::CTRL_WD_IRQ_BIT])) begin
      s_next.irq = 1'b1;
    end
    // reset request lasts exactly one cycle
    s_next.reset_req = ((wd_expire & ~s_reg.ctrl[wdt_pkg::CTRL_WD_IRQ_BIT]) | secure_fail) &
                       ~s_reg.reset_req;
    // read data captured in the cycle before the access completes
    s_next.rd_ready = psel & ~pwrite & ~(penable & s_reg.rd_ready);
    if (psel & ~pwrite) begin
      s_next.prdata = rd_word;
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg.load      <= wdt_pkg::LOAD_RESET;
      s_reg.value     <= wdt_pkg::VALUE_RESET;
      s_reg.ctrl      <= wdt_pkg::CTRL_RESET;
      s_reg.lfsr      <= wdt_pkg::LFSR_RESET;
      s_reg.presc     <= wdt_pkg::PRESC_RESET;
      s_reg.irq       <= 1'b0;
      s_reg.reset_req <= 1'b0;
      s_reg.rd_ready  <= 1'b0;
      s_reg.prdata    <= wdt_pkg::RDATA_RESET;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flip-flops
  assign prdata          = s_reg.prdata;
  assign timer_irq       = s_reg.irq;
  assign wdt_reset_req   = s_reg.reset_req;
  assign watchdog_active = wd_mode;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_secure_service;
    clk_en && wd_mode && clear_write && secure_on;
  endsequence

  sequence s_secure_match;
    s_secure_service ##0 secure_ok;
  endsequence

  property p_reset_pulse;
    wdt_reset_req |=> !wdt_reset_req;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset request longer than one cycle");

  property p_mismatch_reset;
    s_secure_service ##0 (pwdata[7:0] != s_reg.lfsr) |=> wdt_reset_req;
  endproperty
  a_mismatch_reset: assert property (p_mismatch_reset) else $error("bad service did not reset");

  property p_zero_seed;
    s_secure_service ##0 (s_reg.lfsr == 8'h00) |=> wdt_reset_req;
  endproperty
  a_zero_seed: assert property (p_zero_seed) else $error("zero state did not reset");

  property p_lfsr_advance;
    s_secure_match |=> (s_reg.lfsr == wdt_pkg::lfsr_next($past(s_reg.lfsr))) && !wdt_reset_req;
  endproperty
  a_lfsr_advance: assert property (p_lfsr_advance) else $error("lfsr did not advance on match");

  property p_load_locked;
    clk_en && wd_mode |=> $stable(s_reg.load) && s_reg.ctrl == $past(s_reg.ctrl);
  endproperty
  a_load_locked: assert property (p_load_locked) else $error("locked register changed");

  property p_service_reload;
    clk_en && service_ok |=> s_reg.value == $past(s_reg.load);
  endproperty
  a_service_reload: assert property (p_service_reload) else $error("service did not reload");

  property p_expiry_reset;
    clk_en && wd_expire && !s_reg.ctrl[wdt_pkg::CTRL_WD_IRQ_BIT] && !wdt_reset_req |=> wdt_reset_req;
  endproperty
  a_expiry_reset: assert property (p_expiry_reset) else $error("expiry gave no reset");

  property p_expiry_irq;
    clk_en && wd_expire && s_reg.ctrl[wdt_pkg::CTRL_WD_IRQ_BIT] |=> timer_irq ##0 !wdt_reset_req;
  endproperty
  a_expiry_irq: assert property (p_expiry_irq) else $error("expiry gave no interrupt");

  property p_normal_clear;
    clk_en && !wd_mode && clear_write && !norm_event |=> !timer_irq;
  endproperty
  a_normal_clear: assert property (p_normal_clear) else $error("clear write left interrupt set");

  property p_disabled_hold;
    clk_en && !wd_mode && !s_reg.ctrl[wdt_pkg::CTRL_ENABLE_BIT] && !wr_acc |=> $stable(s_reg.value);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) else $error("disabled timer counted");

  property p_norm_irq;
    clk_en && norm_event |=> timer_irq;
  endproperty
  a_norm_irq: assert property (p_norm_irq) else $error("limit reached without interrupt");

  property p_wd_osc_only;
    clk_en && wd_mode && !tick_osc_32k && !clear_write |=> $stable(s_reg.value);
  endproperty
  a_wd_osc_only: assert property (p_wd_osc_only) else $error("watchdog counted without oscillator tick");

  property p_wd_count_down;
    clk_en && wd_mode && step && !wd_expire && !clear_write |=> s_reg.value == $past(s_reg.value) - 16'h0001;
  endproperty
  a_wd_count_down: assert property (p_wd_count_down) else $error("watchdog did not count down");

  property p_up_count;
    clk_en && step && count_up && (s_reg.value != wdt_pkg::COUNT_FULL) && !wr_acc
      |=> s_reg.value == $past(s_reg.value) + 16'h0001;
  endproperty
  a_up_count: assert property (p_up_count) else $error("up count did not increment");

  property p_periodic_restart;
    clk_en && step && !wd_mode && periodic && !count_up && (s_reg.value == wdt_pkg::COUNT_ZERO) && !wr_acc
      |=> s_reg.value == $past(s_reg.load);
  endproperty
  a_periodic_restart: assert property (p_periodic_restart) else $error("periodic count did not restart");

  property p_count_readonly;
    clk_en && wr_acc && sel_value && !step |=> $stable(s_reg.value);
  endproperty
  a_count_readonly: assert property (p_count_readonly) else $error("count register took a write");

  property p_clear_reads_zero;
    clk_en && psel && !pwrite && sel_clear |=> prdata == 32'h0000_0000;
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear register read not zero");

  property p_wd_sticky;
    watchdog_active |=> watchdog_active;
  endproperty
  a_wd_sticky: assert property (p_wd_sticky) else $error("watchdog mode left without reset");

  property p_enter_watchdog;
    wr_acc && sel_ctrl && !wd_mode && pwdata[wdt_pkg::CTRL_WATCHDOG_BIT] |=> watchdog_active;
  endproperty
  a_enter_watchdog: assert property (p_enter_watchdog) else $error("control write did not enter watchdog");

endmodule

// File: hdl/wdt_pkg.sv
// constants, types and helpers shared by the watchdog timer
package wdt_pkg;

  // ---------------------------------------------------------------
  // register byte offsets on the apb bus
  // ---------------------------------------------------------------
  localparam logic [7:0] LOAD_OFFSET    = 8'h00;
  localparam logic [7:0] VALUE_OFFSET   = 8'h04;
  localparam logic [7:0] CONTROL_OFFSET = 8'h08;
  localparam logic [7:0] CLEAR_OFFSET   = 8'h0c;

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int CTRL_COUNT_UP_BIT = 8;
  localparam int CTRL_ENABLE_BIT   = 7;
  localparam int CTRL_PERIODIC_BIT = 6;
  localparam int CTRL_WATCHDOG_BIT = 5;
  localparam int CTRL_SECURE_BIT   = 4;
  localparam int CTRL_PRESC_HI_BIT = 3;
  localparam int CTRL_PRESC_LO_BIT = 2;
  localparam int CTRL_WD_IRQ_BIT   = 1;
  localparam logic [8:0] CTRL_WRITE_MASK = 9'h1fe;

  // ---------------------------------------------------------------
  // values after reset and counter limits
  // ---------------------------------------------------------------
  localparam logic [15:0] LOAD_RESET   = 16'h0000;
  localparam logic [15:0] VALUE_RESET  = 16'h0000;
  localparam logic [8:0]  CTRL_RESET   = 9'h000;
  localparam logic [7:0]  LFSR_RESET   = 8'h00;
  localparam logic [7:0]  PRESC_RESET  = 8'h00;
  localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;
  localparam logic [15:0] COUNT_ZERO   = 16'h0000;
  localparam logic [15:0] COUNT_FULL   = 16'hffff;
  localparam logic [7:0]  LFSR_ZERO    = 8'h00;
  localparam logic [7:0]  LFSR_TAPS    = 8'h63;

  // ---------------------------------------------------------------
  // prescaler terminal counts (divide minus one)
  // ---------------------------------------------------------------
  localparam logic [7:0] PRESC_TERM_DIV1   = 8'h00;
  localparam logic [7:0] PRESC_TERM_DIV16  = 8'h0f;
  localparam logic [7:0] PRESC_TERM_DIV256 = 8'hff;

  typedef enum logic [1:0] {
    PRESC_DIV1   = 2'b00,
    PRESC_DIV16  = 2'b01,
    PRESC_DIV256 = 2'b10,
    PRESC_ALIAS  = 2'b11
  } presc_sel_type;

  // ---------------------------------------------------------------
  // whole state of the block
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] load;
    logic [15:0] value;
    logic [8:0]  ctrl;
    logic [7:0]  lfsr;
    logic [7:0]  presc;
    logic        irq;
    logic        reset_req;
    logic        rd_ready;
    logic [31:0] prdata;
  } wdt_state_type;

  // galois step: shift left, fold the dropped bit back through the taps
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    lfsr_next = {s[6:0], 1'b0} ^ (s[7] ? LFSR_TAPS : LFSR_ZERO);
  endfunction

  // terminal count of the prescaler for a select code
  function automatic logic [7:0] presc_terminal(input presc_sel_type sel);
    unique case (sel)
      PRESC_DIV1:   presc_terminal = PRESC_TERM_DIV1;
      PRESC_DIV16:  presc_terminal = PRESC_TERM_DIV16;
      PRESC_DIV256: presc_terminal = PRESC_TERM_DIV256;
      PRESC_ALIAS:  presc_terminal = PRESC_TERM_DIV1;
    endcase
  endfunction

endpackage

// File: bench/watchdog_timer_tb_top.sv
// self-checking testbench for the watchdog timer
`timescale 1ns/1ps
module watchdog_timer_tb_top;
  // ---------------------------------------------------------------
  // signals and bookkeeping
  // ---------------------------------------------------------------
  localparam logic [7:0] a_load = wdt_pkg::LOAD_OFFSET;
  localparam logic [7:0] a_val  = wdt_pkg::VALUE_OFFSET;
  localparam logic [7:0] a_ctl  = wdt_pkg::CONTROL_OFFSET;
  localparam logic [7:0] a_clr  = wdt_pkg::CLEAR_OFFSET;
  logic        sys_clk;
  logic        arst_n;
  logic        clk_en;
  logic        tick_pll_32k;
  logic        tick_osc_32k;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        timer_irq;
  logic        wdt_reset_req;
  logic        watchdog_active;
  logic        last_err;
  logic        prev_req;
  logic [7:0]  s;
  int          mismatches = 0;
  int          total_checks = 0;
  int          pulses = 0;
  int          cycles = 0;

  watchdog_timer DUT (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .tick_pll_32k(tick_pll_32k),
    .tick_osc_32k(tick_osc_32k), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_irq(timer_irq),
    .wdt_reset_req(wdt_reset_req), .watchdog_active(watchdog_active));

  // 250 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // count reset request pulses, catch stretched ones, cut a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (wdt_reset_req === 1'b1) pulses++;
    if (wdt_reset_req === 1'b1 && prev_req === 1'b1) begin
      mismatches++;
      $display("CHECK FAILED t=%0t req=%h exp=%h", $time, 2'b11, 2'b10);
    end
    prev_req = wdt_reset_req;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // compare, bus and stimulus tasks
  // ---------------------------------------------------------------
  task check32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-bit flag compare; callers arrive after the cause has landed
  task check1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; pready, read data and error are taken at the completing rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    q = prdata;
    last_err = pslverr;
    if (pready !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED t=%0t pready=%h exp=%h", $time, pready, 1'b1);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // let the completing edge's register updates land before the caller looks
    @(posedge sys_clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task rd_check(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    check32(q, e);
  endtask

  // n single-cycle ticks on the pll or the oscillator source
  task tick(input logic osc, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      tick_pll_32k <= ~osc;
      tick_osc_32k <= osc;
      @(posedge sys_clk);
      tick_pll_32k <= 1'b0;
      tick_osc_32k <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
  endtask

  task do_reset;
    arst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    pulses = 0;
  endtask

  function automatic logic [7:0] lfsr_step(input logic [7:0] v);
    lfsr_step = {v[6:0], 1'b0} ^ (v[7] ? 8'h63 : 8'h00);
  endfunction

  task print_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    tick_pll_32k = 1'b0;
    tick_osc_32k = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    do_reset();
    rd_check(a_load, 32'h0000_0000);
    rd_check(a_val, 32'h0000_0000);
    rd_check(a_ctl, 32'h0000_0000);
    rd_check(a_clr, 32'h0000_0000);
    rd_check(8'h10, 32'h0000_0000);
    check1(last_err, 1'b1);
    check1(watchdog_active, 1'b0);
    // normal mode, down, free-running, divide by one
    wr(a_load, 32'h0000_0003);
    wr(a_ctl, 32'h0000_0080);
    rd_check(a_val, 32'h0000_0003);
    tick(1'b0, 3);
    rd_check(a_val, 32'h0000_0000);
    check1(timer_irq, 1'b1);
    wr(a_clr, 32'h0000_0005);
    check1(timer_irq, 1'b0);
    tick(1'b0, 1);
    rd_check(a_val, 32'h0000_ffff);
    tick(1'b1, 1);
    rd_check(a_val, 32'h0000_ffff);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    tick(1'b0, 1);
    clk_en <= 1'b1;
    rd_check(a_val, 32'h0000_ffff);
    // prescale codes and periodic restart
    wr(a_load, 32'h0000_0002);
    wr(a_ctl, 32'h0000_00c4);
    tick(1'b0, 15);
    rd_check(a_val, 32'h0000_0002);
    tick(1'b0, 1);
    rd_check(a_val, 32'h0000_0001);
    tick(1'b0, 16);
    rd_check(a_val, 32'h0000_0000);
    tick(1'b0, 16);
    rd_check(a_val, 32'h0000_0002);
    wr(a_ctl, 32'h0000_00c5);
    rd_check(a_ctl, 32'h0000_00c4);
    wr(a_load, 32'h0000_0001);
    wr(a_ctl, 32'h0000_0088);
    tick(1'b0, 255);
    rd_check(a_val, 32'h0000_0001);
    tick(1'b0, 1);
    rd_check(a_val, 32'h0000_0000);
    wr(a_load, 32'h0000_0005);
    wr(a_ctl, 32'h0000_008c);
    tick(1'b0, 1);
    rd_check(a_val, 32'h0000_0004);
    // counting up to full scale and wrapping
    wr(a_load, 32'h0000_fffe);
    wr(a_clr, 32'h0000_0000);
    wr(a_ctl, 32'h0000_0180);
    tick(1'b0, 1);
    rd_check(a_val, 32'h0000_ffff);
    check1(timer_irq, 1'b1);
    tick(1'b0, 1);
    rd_check(a_val, 32'h0000_0000);
    // counting up in periodic mode restarts from the load value
    wr(a_ctl, 32'h0000_01c0);
    tick(1'b0, 2);
    rd_check(a_val, 32'h0000_fffe);
    // disabled timer holds, count register is read-only
    wr(a_load, 32'h0000_0007);
    wr(a_ctl, 32'h0000_0000);
    tick(1'b0, 2);
    rd_check(a_val, 32'h0000_0007);
    wr(a_val, 32'h0000_1234);
    rd_check(a_val, 32'h0000_0007);
    // watchdog with the interrupt option
    do_reset();
    wr(a_load, 32'h0000_0002);
    wr(a_ctl, 32'h0000_0022);
    check1(watchdog_active, 1'b1);
    tick(1'b1, 1);
    rd_check(a_val, 32'h0000_0001);
    tick(1'b0, 1);
    rd_check(a_val, 32'h0000_0001);
    wr(a_clr, 32'h0000_0000);
    rd_check(a_val, 32'h0000_0002);
    tick(1'b1, 3);
    rd_check(a_val, 32'h0000_0002);
    check1(timer_irq, 1'b1);
    check32(pulses, 32'h0000_0000);
    wr(a_load, 32'h0000_0009);
    wr(a_ctl, 32'h0000_0000);
    rd_check(a_load, 32'h0000_0002);
    rd_check(a_ctl, 32'h0000_0022);
    // watchdog expiry requests a reset
    do_reset();
    wr(a_load, 32'h0000_0001);
    wr(a_ctl, 32'h0000_0020);
    tick(1'b1, 2);
    check32(pulses, 32'h0000_0001);
    // secure clear: seed, three good services, one bad
    do_reset();
    wr(a_clr, 32'h0000_00aa);
    wr(a_load, 32'h0000_0010);
    wr(a_ctl, 32'h0000_0030);
    s = 8'haa;
    repeat (3) begin
      wr(a_clr, {24'h000000, s});
      s = lfsr_step(s);
    end
    tick(1'b1, 1);
    rd_check(a_val, 32'h0000_000f);
    check32(pulses, 32'h0000_0000);
    wr(a_clr, {24'h000000, s ^ 8'hba});
    repeat (3) @(posedge sys_clk);
    check32(pulses, 32'h0000_0001);
    // zero seed always fails
    do_reset();
    wr(a_ctl, 32'h0000_0030);
    wr(a_clr, 32'h0000_0000);
    repeat (3) @(posedge sys_clk);
    check32(pulses, 32'h0000_0001);
    print_verdict();
  end
endmodule
